// ==== rtl/cxr_regs.sv ====
`timescale 1ns/100ps
// Behaviour
// - the debug resume counter is read/write, 32 bits in 32-bit mode, 64 in 64-bit mode, no reset.
// - a debug exception loads the faulting address, or the branch address for a delay slot.
// - when a move write and a debug exception hit the debug resume counter together, hardware wins.
// - low tag bits 31:8 hold physical address 35:12, read/write, reset to zero.
// - low tag bits 7:6 are the line state, 0 invalid, 3 valid, 1 and 2 reserved, reset zero.
// - low tag bit 2 is the read/write lock flag, resetting to 0.
// - low tag bits 5:3 are a read/write field for the operating system, reset zero.
// - high tag bit 31 and low tag bit 1 together select the way to replace, 00 way0 to 11 way3.
// - high tag bit 30 holds physical address bit 11; high 29:0 and low bit 0 read as zero.
// - the tag pair is loaded both by the cache instruction and by a move write.
// - power-on reset, warm restart or non-maskable interrupt capture the pc into the error counter.
// - the error counter gets the faulting address, or the preceding branch for a delay slot.
// - the error counter carries no delay-slot indicator bit.
// - the error counter is read/write, 32 bits in 32-bit mode, 64 in 64-bit mode, no reset.
// - the debug scratch register is 64-bit read/write in both modes with no reset.
module cxr_regs (
    input wire logic clk, // 200 MHz core clock
    input wire logic rst_n, // synchronous cold reset, active low
    input wire logic mode64, // 1: 64-bit address mode
    input wire cxr_pkg::cxr_cpwr_s cp_wr, // coprocessor move write
    input wire logic rd_en, // coprocessor move read request
    input wire logic [4:0] rd_sel, // register number to read
    output logic [63:0] rd_data, // read data, one cycle after rd_en
    output logic rd_valid, // read data valid pulse
    input wire cxr_pkg::cxr_exc_s dbg_exc, // debug exception report
    input wire cxr_pkg::cxr_exc_s err_exc, // power-on, warm restart or nmi report
    input wire cxr_pkg::cxr_tagop_s tag_op, // cache instruction tag load
    output logic [31:0] cache_tag_low, // low tag register
    output logic [31:0] cache_tag_high, // high tag register
    output logic [1:0] replace_way, // selected way for replacement
    output logic [63:0] debug_resume_pc, // resume address after debug handler
    output logic [63:0] error_resume_pc // resume address after error handler
);
    logic [63:0] debug_resume_pc_r;
    logic [63:0] error_resume_pc_r;
    logic [63:0] debug_scratch_r;
    logic [31:0] cache_tag_low_r;
    logic [31:0] cache_tag_high_r;
    logic [63:0] rd_data_r;
    logic rd_valid_r;
    logic [63:0] rd_data_nxt;

    // fit a value to the current address width
    function automatic logic [63:0] cxr_fit(input logic [63:0] v, input logic m64);
        cxr_fit = m64 ? v : (v & cxr_pkg::MODE32_MASK);
    endfunction : cxr_fit

    // resume point: the branch when the fault sits in its delay slot
    function automatic logic [63:0] cxr_resume(input cxr_pkg::cxr_exc_s e, input logic m64);
        cxr_resume = cxr_fit(e.in_delay_slot ? e.branch_pc : e.pc, m64);
    endfunction : cxr_resume

    // move-write hit on one register number; shared by the counter and scratch write paths and the checks
    function automatic logic cxr_wr_hit(input cxr_pkg::cxr_cpwr_s w, input logic [4:0] num);
        cxr_wr_hit = w.wr && (w.sel == num);
    endfunction : cxr_wr_hit

    // debug resume counter; no reset, its value is undefined until written
    always_ff @(posedge clk) begin
        if (dbg_exc.take) begin
            debug_resume_pc_r <= cxr_resume(dbg_exc, mode64);
        end else if (cxr_wr_hit(cp_wr, cxr_pkg::REG_DEBUG_RESUME_PC)) begin
            debug_resume_pc_r <= cxr_fit(cp_wr.data, mode64);
        end
    end

    // error resume counter; only the address is kept, no delay-slot flag exists
    always_ff @(posedge clk) begin
        if (err_exc.take) begin
            error_resume_pc_r <= cxr_resume(err_exc, mode64);
        end else if (cxr_wr_hit(cp_wr, cxr_pkg::REG_ERROR_RESUME_PC)) begin
            error_resume_pc_r <= cxr_fit(cp_wr.data, mode64);
        end
    end

    // debug scratch: full 64 bits in both modes
    always_ff @(posedge clk) begin
        if (cxr_wr_hit(cp_wr, cxr_pkg::REG_DEBUG_SCRATCH)) begin
            debug_scratch_r <= cp_wr.data;
        end
    end

    // tag pair; cache instruction beats a same-cycle move write to keep the pair coherent
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cache_tag_low_r <= cxr_pkg::TAG_LOW_RESET;
            cache_tag_high_r <= cxr_pkg::TAG_HIGH_RESET;
        end else if (tag_op.load) begin
            cache_tag_low_r <= tag_op.low & cxr_pkg::TAG_LOW_WR_MASK;
            cache_tag_high_r <= tag_op.high & cxr_pkg::TAG_HIGH_WR_MASK;
        end else if (cp_wr.wr) begin
            if (cp_wr.sel == cxr_pkg::REG_CACHE_TAG_LOW) begin
                cache_tag_low_r <= cp_wr.data[31:0] & cxr_pkg::TAG_LOW_WR_MASK;
            end
            if (cp_wr.sel == cxr_pkg::REG_CACHE_TAG_HIGH) begin
                cache_tag_high_r <= cp_wr.data[31:0] & cxr_pkg::TAG_HIGH_WR_MASK;
            end
        end
    end

    // read mux; unknown register numbers read as zero
    always_comb begin
        case (rd_sel)
            cxr_pkg::REG_DEBUG_RESUME_PC: rd_data_nxt = cxr_fit(debug_resume_pc_r, mode64);
            cxr_pkg::REG_CACHE_TAG_LOW: rd_data_nxt = {32'h00000000, cache_tag_low_r};
            cxr_pkg::REG_CACHE_TAG_HIGH: rd_data_nxt = {32'h00000000, cache_tag_high_r};
            cxr_pkg::REG_ERROR_RESUME_PC: rd_data_nxt = cxr_fit(error_resume_pc_r, mode64);
            cxr_pkg::REG_DEBUG_SCRATCH: rd_data_nxt = debug_scratch_r;
            default: rd_data_nxt = cxr_pkg::RD_DATA_RESET;
        endcase
    end

    // registered read port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_r <= cxr_pkg::RD_DATA_RESET;
            rd_valid_r <= 1'h0;
        end else begin
            rd_valid_r <= rd_en;
            if (rd_en) begin
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign cache_tag_low = cache_tag_low_r;
    assign cache_tag_high = cache_tag_high_r;
    // way select: high bit from the high tag, low bit from the low tag
    assign replace_way = {cache_tag_high_r[cxr_pkg::REPLACE_WAY_MSB_BIT],
                          cache_tag_low_r[cxr_pkg::REPLACE_WAY_LSB_BIT]};
    assign debug_resume_pc = debug_resume_pc_r;
    assign error_resume_pc = error_resume_pc_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_dbg_clash;
        dbg_exc.take && cp_wr.wr && cp_wr.sel == cxr_pkg::REG_DEBUG_RESUME_PC;
    endsequence

    sequence s_low_write;
        cp_wr.wr && !tag_op.load && cp_wr.sel == cxr_pkg::REG_CACHE_TAG_LOW;
    endsequence

    AST_DBG_LOAD: assert property (dbg_exc.take |=>
        debug_resume_pc_r == cxr_resume($past(dbg_exc), $past(mode64)))
        else $error("debug resume counter missed the exception address");

    AST_DBG_HW_WINS: assert property (s_dbg_clash |=>
        debug_resume_pc_r != cxr_fit($past(cp_wr.data), $past(mode64))
        || cxr_fit($past(cp_wr.data), $past(mode64)) == cxr_resume($past(dbg_exc), $past(mode64)))
        else $error("software write beat the debug exception");

    AST_ERR_LOAD: assert property (err_exc.take |=>
        error_resume_pc_r == cxr_resume($past(err_exc), $past(mode64)))
        else $error("error resume counter missed the pc");

    AST_ERR_READ: assert property (rd_en && rd_sel == cxr_pkg::REG_ERROR_RESUME_PC
        && !mode64 |=> rd_valid_r && rd_data_r[63:32] == 32'h00000000)
        else $error("error counter read shows upper bits in 32-bit mode");

    AST_LINE_FIELDS: assert property (s_low_write |=>
        cache_tag_low_r[31:1] == $past(cp_wr.data[31:1]) && !cache_tag_low_r[0])
        else $error("low tag fields not stored as written");

    AST_TAG_RSVD: assert property (cache_tag_high_r[29:0] == 30'h0
        && cache_tag_low_r[0] == 1'h0)
        else $error("reserved tag bits read nonzero");

    AST_CACHE_OP: assert property (tag_op.load |=>
        cache_tag_high_r == ($past(tag_op.high) & cxr_pkg::TAG_HIGH_WR_MASK)
        && cache_tag_low_r == ($past(tag_op.low) & cxr_pkg::TAG_LOW_WR_MASK))
        else $error("cache instruction did not load the tag pair");

    AST_WAY_SEL: assert property (tag_op.load |=> ##1
        replace_way == {$past(tag_op.high[31], 2), $past(tag_op.low[1], 2)} || $past(tag_op.load)
        || $past(cp_wr.wr))
        else $error("replace way does not follow the tag bits");

    AST_SCRATCH_RD: assert property (rd_en && rd_sel == cxr_pkg::REG_DEBUG_SCRATCH
        |=> rd_valid_r && rd_data_r == $past(debug_scratch_r))
        else $error("scratch read lost bits");

    // plain move writes, with no hardware capture competing in the same cycle
    sequence s_dbg_write;
        cxr_wr_hit(cp_wr, cxr_pkg::REG_DEBUG_RESUME_PC) && !dbg_exc.take;
    endsequence

    sequence s_err_write;
        cxr_wr_hit(cp_wr, cxr_pkg::REG_ERROR_RESUME_PC) && !err_exc.take;
    endsequence

    sequence s_high_write;
        cp_wr.wr && !tag_op.load && cp_wr.sel == cxr_pkg::REG_CACHE_TAG_HIGH;
    endsequence

    AST_DBG_WRITE: assert property (s_dbg_write |=>
        debug_resume_pc_r == cxr_fit($past(cp_wr.data), $past(mode64)))
        else $error("debug resume counter lost a move write");

    AST_ERR_WRITE: assert property (s_err_write |=>
        error_resume_pc_r == cxr_fit($past(cp_wr.data), $past(mode64)))
        else $error("error resume counter lost a move write");

    // only bits 31 and 30 of the high tag may follow the write data
    AST_HIGH_WRITE: assert property (s_high_write |=>
        cache_tag_high_r == ($past(cp_wr.data[31:0]) & cxr_pkg::TAG_HIGH_WR_MASK))
        else $error("high tag not stored as written");

    // scratch is never trimmed, whatever the address mode
    AST_SCRATCH_WR: assert property (cxr_wr_hit(cp_wr, cxr_pkg::REG_DEBUG_SCRATCH) |=>
        debug_scratch_r == $past(cp_wr.data))
        else $error("scratch lost a move write");

    // the tag pair only moves on a cache instruction or a move write
    AST_TAG_HOLD: assert property (!tag_op.load && !cp_wr.wr |=>
        $stable(cache_tag_low_r) && $stable(cache_tag_high_r))
        else $error("tag pair changed with no write");

    AST_DBG_RD32: assert property (rd_en && rd_sel == cxr_pkg::REG_DEBUG_RESUME_PC
        && !mode64 |=> rd_valid_r && rd_data_r[63:32] == 32'h00000000)
        else $error("debug counter read shows upper bits in 32-bit mode");
endmodule : cxr_regs

// ==== rtl/cxr_pkg.sv ====
package cxr_pkg;
    // coprocessor register numbers used by the move instructions
    localparam logic [4:0] REG_DEBUG_RESUME_PC = 5'h18;
    localparam logic [4:0] REG_CACHE_TAG_LOW = 5'h1C;
    localparam logic [4:0] REG_CACHE_TAG_HIGH = 5'h1D;
    localparam logic [4:0] REG_ERROR_RESUME_PC = 5'h1E;
    localparam logic [4:0] REG_DEBUG_SCRATCH = 5'h1F;

    // low tag field positions
    localparam int PHYS_TAG_UPPER_MSB = 31;
    localparam int PHYS_TAG_UPPER_LSB = 8;
    localparam int LINE_STATE_MSB = 7;
    localparam int LINE_STATE_LSB = 6;
    localparam int OS_ACCESS_MSB = 5;
    localparam int OS_ACCESS_LSB = 3;
    localparam int LINE_LOCK_BIT = 2;
    localparam int REPLACE_WAY_LSB_BIT = 1;
    // high tag field positions
    localparam int REPLACE_WAY_MSB_BIT = 31;
    localparam int PHYS_TAG_BIT11_BIT = 30;

    // writable bits; everything else reads as zero
    localparam logic [31:0] TAG_LOW_WR_MASK = 32'hFFFFFFFE;
    localparam logic [31:0] TAG_HIGH_WR_MASK = 32'hC0000000;
    localparam logic [31:0] TAG_LOW_RESET = 32'h00000000;
    localparam logic [31:0] TAG_HIGH_RESET = 32'h00000000;
    localparam logic [63:0] MODE32_MASK = 64'h00000000FFFFFFFF;
    localparam logic [63:0] RD_DATA_RESET = 64'h0000000000000000;

    // line state encodings
    localparam logic [1:0] LINE_STATE_INVALID = 2'h0;
    localparam logic [1:0] LINE_STATE_VALID = 2'h3;

    // one exception report from the pipeline
    typedef struct packed {
        logic take;            // one-cycle pulse
        logic in_delay_slot;   // faulting instruction sits in a delay slot
        logic [63:0] pc;       // faulting instruction address
        logic [63:0] branch_pc; // preceding branch or jump address
    } cxr_exc_s;

    // coprocessor move write
    typedef struct packed {
        logic wr;
        logic [4:0] sel;
        logic [63:0] data;
    } cxr_cpwr_s;

    // tag pair as loaded by the cache instruction
    typedef struct packed {
        logic load;
        logic [31:0] low;
        logic [31:0] high;
    } cxr_tagop_s;
endpackage : cxr_pkg

// ==== tb/cxr_regs_tb.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module cxr_regs_tb;
    logic clk;
    logic rst_n;
    logic mode64;
    cxr_pkg::cxr_cpwr_s cp_wr;
    logic rd_en;
    logic [4:0] rd_sel;
    logic [63:0] rd_data;
    logic rd_valid;
    cxr_pkg::cxr_exc_s dbg_exc;
    cxr_pkg::cxr_exc_s err_exc;
    cxr_pkg::cxr_tagop_s tag_op;
    logic [31:0] cache_tag_low;
    logic [31:0] cache_tag_high;
    logic [1:0] replace_way;
    logic [63:0] debug_resume_pc;
    logic [63:0] error_resume_pc;
    logic [63:0] exp_q[$];
    logic [63:0] d, p, b, e;
    logic [31:0] lo, hi;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    cxr_regs cxr_regs_inst (.clk(clk), .rst_n(rst_n), .mode64(mode64), .cp_wr(cp_wr),
        .rd_en(rd_en), .rd_sel(rd_sel), .rd_data(rd_data), .rd_valid(rd_valid),
        .dbg_exc(dbg_exc), .err_exc(err_exc), .tag_op(tag_op), .cache_tag_low(cache_tag_low),
        .cache_tag_high(cache_tag_high), .replace_way(replace_way),
        .debug_resume_pc(debug_resume_pc), .error_resume_pc(error_resume_pc));

    // 200 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic results;
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    // the whole run needs about a hundred cycles, well short of the 3000-cycle budget that stops a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("wrong value at %0t: run did not finish", $time);
            results();
        end
    end

    // read results appear a cycle after the request; checked at the settled falling edge
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("wrong value at %0t: read data with no request", $time);
            end else begin
                e = exp_q.pop_front();
                `CHK(rd_data, e)
            end
        end
    end

    // k: bit0 move write, bit1 debug take, bit2 error take, bit3 cache-op load from pc
    task automatic op(input logic [3:0] k, input logic [4:0] sel, input logic [63:0] dat,
                      input logic ds, input logic [63:0] pc, input logic [63:0] bp);
        @(negedge clk);
        cp_wr = '{wr: k[0], sel: sel, data: dat};
        dbg_exc = '{take: k[1], in_delay_slot: ds, pc: pc, branch_pc: bp};
        err_exc = '{take: k[2], in_delay_slot: ds, pc: pc, branch_pc: bp};
        tag_op = '{load: k[3], low: pc[31:0], high: pc[63:32]};
        @(negedge clk);
        cp_wr = '{wr: 1'b0, sel: 5'h00, data: ~dat};
        dbg_exc.take = 1'b0;
        err_exc.take = 1'b0;
        tag_op.load = 1'b0;
    endtask : op

    // the expectation is queued before the request goes out
    task automatic rd(input logic [4:0] sel, input logic [63:0] ex);
        @(negedge clk);
        exp_q.push_back(ex);
        rd_en = 1'b1;
        rd_sel = sel;
        @(negedge clk);
        rd_en = 1'b0;
    endtask : rd

    function automatic logic [63:0] rnd64();
        return {$urandom(), $urandom()};
    endfunction : rnd64

    initial begin
        d = $urandom(70402);
        {cp_wr, dbg_exc, err_exc, tag_op, rd_en, rd_sel} = '0;
        rst_n = 1'b0;
        mode64 = 1'b1;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rd(cxr_pkg::REG_CACHE_TAG_LOW, 64'h0);
        rd(cxr_pkg::REG_CACHE_TAG_HIGH, 64'h0);
        rd(5'h00, 64'h0);
        `CHK(replace_way, 2'h0)
        $display("test reset done");
        // every way and every line state code, with random reserved bits set
        for (int w = 0; w < 4; w++) begin
            lo = $urandom();
            hi = $urandom();
            lo[1] = w[0];
            hi[31] = w[1];
            lo[7:6] = w[1:0];
            op(4'h1, cxr_pkg::REG_CACHE_TAG_LOW, {$urandom(), lo}, 1'b0, 64'h0, 64'h0);
            op(4'h1, cxr_pkg::REG_CACHE_TAG_HIGH, {32'h0, hi}, 1'b0, 64'h0, 64'h0);
            rd(cxr_pkg::REG_CACHE_TAG_LOW, {32'h0, lo & 32'hFFFFFFFE});
            rd(cxr_pkg::REG_CACHE_TAG_HIGH, {32'h0, hi & 32'hC0000000});
            `CHK(replace_way, w[1:0])
            `CHK(cache_tag_low, lo & 32'hFFFFFFFE)
            `CHK(cache_tag_high, hi & 32'hC0000000)
        end
        p = rnd64();
        op(4'h9, cxr_pkg::REG_CACHE_TAG_LOW, rnd64(), 1'b0, p, 64'h0);
        rd(cxr_pkg::REG_CACHE_TAG_LOW, {32'h0, p[31:0] & 32'hFFFFFFFE});
        rd(cxr_pkg::REG_CACHE_TAG_HIGH, {32'h0, p[63:32] & 32'hC0000000});
        `CHK(cache_tag_high, p[63:32] & 32'hC0000000)
        // a mid-run reset has to clear the loaded pair again
        @(negedge clk);
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rd(cxr_pkg::REG_CACHE_TAG_LOW, 64'h0);
        `CHK(cache_tag_high, 32'h0)
        `CHK(replace_way, 2'h0)
        $display("test tags done");
        d = rnd64();
        p = rnd64();
        b = rnd64();
        op(4'h1, cxr_pkg::REG_DEBUG_RESUME_PC, d, 1'b0, 64'h0, 64'h0);
        rd(cxr_pkg::REG_DEBUG_RESUME_PC, d);
        op(4'h2, 5'h00, 64'h0, 1'b0, p, b);
        rd(cxr_pkg::REG_DEBUG_RESUME_PC, p);
        op(4'h2, 5'h00, 64'h0, 1'b1, p, b);
        `CHK(debug_resume_pc, b)
        op(4'h3, cxr_pkg::REG_DEBUG_RESUME_PC, d, 1'b0, p, b);
        rd(cxr_pkg::REG_DEBUG_RESUME_PC, p);
        op(4'h4, 5'h00, 64'h0, 1'b1, p, b);
        rd(cxr_pkg::REG_ERROR_RESUME_PC, b);
        op(4'h5, cxr_pkg::REG_ERROR_RESUME_PC, d, 1'b0, p, b);
        `CHK(error_resume_pc, p)
        op(4'h1, cxr_pkg::REG_ERROR_RESUME_PC, d, 1'b0, 64'h0, 64'h0);
        rd(cxr_pkg::REG_ERROR_RESUME_PC, d);
        op(4'h1, cxr_pkg::REG_DEBUG_SCRATCH, ~d, 1'b0, 64'h0, 64'h0);
        rd(cxr_pkg::REG_DEBUG_SCRATCH, ~d);
        $display("test 64-bit counters done");
        // 32-bit mode keeps only the low word of the counters, scratch stays 64 bits
        @(negedge clk);
        mode64 = 1'b0;
        op(4'h1, cxr_pkg::REG_DEBUG_RESUME_PC, d, 1'b0, 64'h0, 64'h0);
        rd(cxr_pkg::REG_DEBUG_RESUME_PC, d & cxr_pkg::MODE32_MASK);
        op(4'h4, 5'h00, 64'h0, 1'b1, p, b);
        rd(cxr_pkg::REG_ERROR_RESUME_PC, b & cxr_pkg::MODE32_MASK);
        op(4'h1, cxr_pkg::REG_DEBUG_SCRATCH, d, 1'b0, 64'h0, 64'h0);
        rd(cxr_pkg::REG_DEBUG_SCRATCH, d);
        repeat (3) @(negedge clk);
        `CHK(exp_q.size(), 0)
        $display("test 32-bit counters done");
        results();
    end
endmodule : cxr_regs_tb
